// ===== logic/usb_link_power_cfg.sv
// wishbone register bank for u1 link power, latency messaging and gap trims
// assumes a classic wishbone master, 250 MHz clock, loader supplies image values
// Contract
// - self-started u1 only when enable bit and host feature are both set
// - accept host u1 requests when enable bit set, independent of bit 10
// - latency messaging enabled exactly while its bit is set
// - enable bits survive protected resets instead of returning to defaults
// - full-speed trim counts phy clocks, scaled and added to gap timeout
// - each full-speed count adds 0.2 bit times at 60 MHz
// - uncalibrated full-speed gap timeout lies within 16 to 18 bits
// - outside full speed the high-speed trim goes to the controller
// - each high-speed count adds 8 bit times
// - self-start and latency bits default from image, else 0; usb reset restores
// - host accept bit defaults from image, else 1; usb reset restores
// - full-speed trim defaults from image, else zero; usb reset restores
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "usb_link_cfg_map.svh"
module usb_link_power_cfg (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  input  wire logic                          we_i,
  input  wire logic [11:0]                   adr_i,
  input  wire logic [3:0]                    sel_i,
  input  wire logic [31:0]                   dat_i,
  output logic      [31:0]                   dat_o,
  output logic                               ack_o,
  input  wire logic                          usb_reset_i,
  input  wire logic                          lite_reset_i,
  input  wire logic                          reset_protect_i,
  input  wire logic                          image_valid_i,
  input  wire usb_link_cfg_pkg::link_cfg_t   image_i,
  input  wire usb_link_cfg_pkg::link_speed_t speed_i,
  input  wire logic                          host_u1_feature_i,
  input  wire logic                          fs_gap_base_ok_i,
  output logic                               u1_self_start_o,
  output logic                               u1_host_req_accept_o,
  output logic                               latency_msg_o,
  output logic      [2:0]                    trim_sel_o,
  output logic      [7:0]                    gap_ext_o
);
  usb_link_cfg_pkg::link_cfg_t cfg;
  usb_link_cfg_pkg::link_cfg_t dflt;
  logic                        self_start_en;
  logic                        host_accept_en;
  logic                        latency_msg_en;
  logic [2:0]                  fs_trim;
  logic [2:0]                  hs_trim;
  logic                        hit;
  logic                        wr;
  logic                        usb_rst;
  logic [31:0]                 rd_word;

  assign hit     = adr_i == `CFG_ONE_OFFSET;
  assign wr      = cyc_i && stb_i && we_i && !ack_o && hit;
  assign usb_rst = usb_reset_i || lite_reset_i;
  // one driver per register; the struct is only a read view of them
  assign cfg     = {self_start_en, host_accept_en, latency_msg_en, fs_trim, hs_trim};

  // image value when loaded, else hard default
  always_comb begin
    if (image_valid_i) begin
      dflt = image_i;
    end else begin
      dflt.self_start_en  = `DEF_SELF_START;
      dflt.host_accept_en = `DEF_HOST_ACCEPT;
      dflt.latency_msg_en = `DEF_LATENCY_MSG;
      dflt.fs_trim        = `DEF_TRIM;
      dflt.hs_trim        = `DEF_TRIM;
    end
  end

  // enable bits: protected resets keep them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      self_start_en  <= `DEF_SELF_START;
      host_accept_en <= `DEF_HOST_ACCEPT;
      latency_msg_en <= `DEF_LATENCY_MSG;
    end else if (usb_rst && !reset_protect_i) begin
      self_start_en  <= dflt.self_start_en;
      host_accept_en <= dflt.host_accept_en;
      latency_msg_en <= dflt.latency_msg_en;
    end else if (wr && sel_i[1]) begin
      self_start_en  <= dat_i[`BIT_SELF_START];
      host_accept_en <= dat_i[`BIT_HOST_ACCEPT];
      latency_msg_en <= dat_i[`BIT_LATENCY_MSG];
    end
  end

  // trims
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_trim <= `DEF_TRIM;
      hs_trim <= `DEF_TRIM;
    end else if (usb_rst) begin
      fs_trim <= dflt.fs_trim;
      hs_trim <= dflt.hs_trim;
    end else if (wr) begin
      if (sel_i[0]) begin
        fs_trim <= dat_i[`FS_TRIM_MSB:`FS_TRIM_LSB];
      end
      if (sel_i[1]) begin
        hs_trim <= dat_i[`HS_TRIM_MSB:`HS_TRIM_LSB];
      end
    end
  end

  always_comb begin
    rd_word                               = 32'h0000_0000;
    rd_word[`BIT_SELF_START]              = cfg.self_start_en;
    rd_word[`BIT_HOST_ACCEPT]             = cfg.host_accept_en;
    rd_word[`BIT_LATENCY_MSG]             = cfg.latency_msg_en;
    rd_word[`FS_TRIM_MSB:`FS_TRIM_LSB]    = cfg.fs_trim;
    rd_word[`HS_TRIM_MSB:`HS_TRIM_LSB]    = cfg.hs_trim;
  end

  // one-cycle answer; unmapped reads return zero and writes drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'h0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= hit ? rd_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      u1_self_start_o      <= 1'h0;
      u1_host_req_accept_o <= 1'h0;
      latency_msg_o        <= 1'h0;
    end else begin
      u1_self_start_o      <= cfg.self_start_en && host_u1_feature_i;
      u1_host_req_accept_o <= cfg.host_accept_en;
      latency_msg_o        <= cfg.latency_msg_en;
    end
  end

  // selected trim scaled into the gap extension
  gap_trim_calc u_calc (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .speed_i    (speed_i),
    .fs_trim_i  (cfg.fs_trim),
    .hs_trim_i  (cfg.hs_trim),
    .trim_sel_o (trim_sel_o),
    .gap_ext_o  (gap_ext_o)
  );

  self_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> u1_self_start_o == ($past(host_u1_feature_i) && $past(cfg.self_start_en)))
    else $error("self start without both enables");

  host_accept_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> u1_host_req_accept_o == $past(cfg.host_accept_en))
    else $error("host accept mismatch");

  latency_msg_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> latency_msg_o == $past(cfg.latency_msg_en))
    else $error("latency messaging mismatch");

  sequence protected_rst_s;
    usb_rst && reset_protect_i && !wr;
  endsequence
  protect_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    protected_rst_s |=> $stable(cfg.host_accept_en) && $stable(cfg.self_start_en) && $stable(cfg.latency_msg_en))
    else $error("protected bit changed");

  fs_ext_a: assert property (@(posedge clk_i) disable iff (rst_i)
    speed_i == usb_link_cfg_pkg::SPD_FULL ##1 $stable(speed_i)
    |-> gap_ext_o == 8'($past(cfg.fs_trim) * `FS_TENTHS_PER_CLK))
    else $error("full speed extension wrong");

  hs_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    speed_i != usb_link_cfg_pkg::SPD_FULL |=> trim_sel_o == $past(cfg.hs_trim))
    else $error("high speed trim not presented");

  gap_base_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fs_gap_base_ok_i && speed_i == usb_link_cfg_pkg::SPD_FULL ##1 $stable(speed_i)
    |-> gap_ext_o <= 8'(3'h7) * 8'(`FS_TENTHS_PER_CLK))
    else $error("gap base bounds broken");

  accept_default_a: assert property (@(posedge clk_i) disable iff (rst_i)
    usb_rst && !reset_protect_i && !image_valid_i |=> cfg.host_accept_en == 1'h1)
    else $error("host accept default not restored");

  trim_default_a: assert property (@(posedge clk_i) disable iff (rst_i)
    usb_rst && !image_valid_i |=> cfg.fs_trim == 3'h0)
    else $error("trim default not restored");

  reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |-> dat_o[7] == 1'h0 && dat_o[3:2] == 2'h0)
    else $error("reserved bits nonzero");
endmodule // usb_link_power_cfg
`default_nettype wire

// ===== logic/usb_link_cfg_map.svh
// register map constants for the usb link power configuration block
// assumes inclusion by bare name from the package and the design files
`ifndef USB_LINK_CFG_MAP_SVH
`define USB_LINK_CFG_MAP_SVH

`define CFG_ONE_OFFSET      12'h084
`define CFG_ADDR_W          12
`define BIT_SELF_START      10
`define BIT_HOST_ACCEPT     9
`define BIT_LATENCY_MSG     8
`define FS_TRIM_LSB         4
`define FS_TRIM_MSB         6
`define HS_TRIM_LSB         13
`define HS_TRIM_MSB         15
`define FS_GAP_BASE_MIN     5'h10
`define FS_GAP_BASE_MAX     5'h12
`define FS_TENTHS_PER_CLK   4'h2
`define HS_BITS_PER_CLK     5'h08
`define DEF_SELF_START      1'h0
`define DEF_HOST_ACCEPT     1'h1
`define DEF_LATENCY_MSG     1'h0
`define DEF_TRIM            3'h0

`endif

// ===== logic/usb_link_cfg_pkg.sv
// types shared by the usb link power configuration block
// assumes the map header defines field positions
`include "usb_link_cfg_map.svh"
package usb_link_cfg_pkg;
  typedef struct packed {
    logic       self_start_en;
    logic       host_accept_en;
    logic       latency_msg_en;
    logic [2:0] fs_trim;
    logic [2:0] hs_trim;
  } link_cfg_t;

  typedef enum logic [1:0] {
    SPD_FULL,
    SPD_HIGH,
    SPD_SUPER
  } link_speed_t;
endpackage

// ===== logic/gap_trim_calc.sv
// turns the selected trim count into the inter-packet gap extension
// assumes speed and trims are stable register outputs
`timescale 1ns/10ps
`default_nettype none
`include "usb_link_cfg_map.svh"
module gap_trim_calc (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire usb_link_cfg_pkg::link_speed_t speed_i,
  input  wire logic [2:0]                   fs_trim_i,
  input  wire logic [2:0]                   hs_trim_i,
  output logic      [2:0]                   trim_sel_o,
  output logic      [7:0]                   gap_ext_o
);
  logic [2:0] next_sel;
  logic [7:0] next_ext;

  always_comb begin
    if (speed_i == usb_link_cfg_pkg::SPD_FULL) begin
      next_sel = fs_trim_i;
      // fifths of a bit, reported in tenths
      next_ext = 8'(fs_trim_i) * 8'(`FS_TENTHS_PER_CLK);
    end else begin
      next_sel = hs_trim_i;
      // eight bits per phy clock
      // widen first: seven counts of eight bits overflow a five-bit product
      next_ext = 8'(hs_trim_i) * 8'(`HS_BITS_PER_CLK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trim_sel_o <= 3'h0;
      gap_ext_o  <= 8'h00;
    end else begin
      trim_sel_o <= next_sel;
      gap_ext_o  <= next_ext;
    end
  end
endmodule // gap_trim_calc
`default_nettype wire

// ===== dv/usb_core_model.sv
// far-side controller model: link speed, u1 feature state, base gap status
// assumes bench requests change right after a rising edge
`timescale 1ns/10ps
`default_nettype none
module usb_core_model (
  input  wire logic                          clk_i,
  input  wire usb_link_cfg_pkg::link_speed_t speed_req_i,
  input  wire logic                          feat_req_i,
  output var usb_link_cfg_pkg::link_speed_t  speed_o,
  output logic                               feat_o,
  output logic                               base_ok_o
);
  // base gap legal
  // own untrimmed timeout always sits within 16 to 18 bits
  assign base_ok_o = 1'h1;
  always_ff @(posedge clk_i) begin
    speed_o <= speed_req_i;
    feat_o  <= feat_req_i;
  end
endmodule // usb_core_model
`default_nettype wire

// ===== dv/test_usb_link_power_cfg.sv
// self-checking bench for the u1 power and gap trim register
// assumes one-cycle wishbone ack and outputs one edge behind the register
`timescale 1ns/10ps
`default_nettype none
`include "usb_link_cfg_map.svh"
module test_usb_link_power_cfg;
  logic                          clk_i = 1'h0, rst_i, cyc, stb, we, ack, ur, lr, prot, img_ok, freq, feat, bok;
  logic                          so, ao, lo;
  logic [11:0]                   adr;
  logic [3:0]                    sel, lanes;
  logic [31:0]                   wd, rdat, dat_o;
  logic [2:0]                    tsel;
  logic [7:0]                    gext;
  usb_link_cfg_pkg::link_cfg_t   img;
  usb_link_cfg_pkg::link_speed_t sreq, spd;
  int                            bad_count = 0, n_compared = 0;
  always #2 clk_i = ~clk_i;
  usb_link_power_cfg dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wd), .dat_o(dat_o), .ack_o(ack), .usb_reset_i(ur), .lite_reset_i(lr),
    .reset_protect_i(prot), .image_valid_i(img_ok), .image_i(img), .speed_i(spd), .host_u1_feature_i(feat),
    .fs_gap_base_ok_i(bok), .u1_self_start_o(so), .u1_host_req_accept_o(ao), .latency_msg_o(lo),
    .trim_sel_o(tsel), .gap_ext_o(gext));
  usb_core_model core (.clk_i(clk_i), .speed_req_i(sreq), .feat_req_i(freq), .speed_o(spd), .feat_o(feat),
    .base_ok_o(bok));
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic bad(input string m);
    bad_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk_rd(input logic [31:0] e);
    n_compared++;
    if (rdat !== e) bad($sformatf("read %h want %h", rdat, e));
  endtask
  task automatic chk_out(input logic [13:0] e);
    n_compared++;
    if ({so, ao, lo, tsel, gext} !== e) bad($sformatf("outputs %h want %h", {so, ao, lo, tsel, gext}, e));
  endtask
  // holds the request until ack is sampled, then releases for an idle cycle
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    sel <= lanes;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 20);
    rdat = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 20) begin
      bad("no ack");
      end_of_test();
    end
  endtask
  task automatic rd(input logic [11:0] a);
    wb(1'h0, a, 32'h0);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic pulse(input logic lite);
    @(posedge clk_i);
    if (lite) lr <= 1'h1;
    else ur <= 1'h1;
    @(posedge clk_i);
    lr <= 1'h0;
    ur <= 1'h0;
  endtask
  task automatic t_defaults;
    rd(`CFG_ONE_OFFSET);
    chk_rd(32'h00000200);
    settle();
    chk_out({3'h2, 3'h0, 8'h00});
    rd(12'h088);
    chk_rd(32'h0);
    $display("defaults done");
  endtask
  task automatic t_enables;
    wb(1'h1, `CFG_ONE_OFFSET, 32'hffffffff);
    rd(`CFG_ONE_OFFSET);
    chk_rd(32'h0000e770);
    settle();
    chk_out({3'h3, 3'h7, 8'h0e});
    freq <= 1'h1;
    settle();
    chk_out({3'h7, 3'h7, 8'h0e});
    wb(1'h1, `CFG_ONE_OFFSET, 32'h00000400);
    settle();
    chk_out({3'h4, 3'h0, 8'h00});
    wb(1'h1, `CFG_ONE_OFFSET, 32'h00000200);
    settle();
    chk_out({3'h2, 3'h0, 8'h00});
    // low lane only: just the full-speed trim may move
    lanes = 4'h1;
    wb(1'h1, `CFG_ONE_OFFSET, 32'hffffffff);
    lanes = 4'hf;
    rd(`CFG_ONE_OFFSET);
    chk_rd(32'h00000270);
    $display("enables done");
  endtask
  task automatic t_trims;
    logic [2:0] f;
    for (int i = 0; i < 8; i++) begin
      f = i[2:0];
      wb(1'h1, `CFG_ONE_OFFSET, {16'h0, ~f, 6'h0, f, 4'h0});
      sreq <= usb_link_cfg_pkg::SPD_FULL;
      settle();
      chk_out({3'h0, f, 4'h0, f, 1'h0});
      sreq <= i[0] ? usb_link_cfg_pkg::SPD_SUPER : usb_link_cfg_pkg::SPD_HIGH;
      settle();
      chk_out({3'h0, ~f, 2'h0, ~f, 3'h0});
    end
    $display("trims done");
  endtask
  task automatic t_resets;
    wb(1'h1, `CFG_ONE_OFFSET, 32'h00002570);
    prot <= 1'h1;
    pulse(1'h0);
    rd(`CFG_ONE_OFFSET);
    chk_rd(32'h00000500);
    prot <= 1'h0;
    pulse(1'h1);
    rd(`CFG_ONE_OFFSET);
    chk_rd(32'h00000200);
    img_ok <= 1'h1;
    img <= '{1'h1, 1'h0, 1'h1, 3'h5, 3'h6};
    pulse(1'h1);
    rd(`CFG_ONE_OFFSET);
    chk_rd(32'h0000c550);
    $display("resets done");
  endtask
  initial begin
    {rst_i, cyc, stb, we, ur, lr, prot, img_ok, freq} = 9'h100;
    adr = 12'h0;
    sel = 4'h0;
    lanes = 4'hf;
    wd = 32'h0;
    img = '0;
    sreq = usb_link_cfg_pkg::SPD_FULL;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    t_defaults();
    t_enables();
    t_trims();
    t_resets();
    end_of_test();
  end
endmodule // test_usb_link_power_cfg
`default_nettype wire
